// >>> bench/rc_osc_model.sv
// Behavioural RC ring oscillator feeding the watchdog clock pin.
// Assumes the device gates it through its enable output.
`timescale 1ns/1ps
module rc_osc_model (
  input  wire logic enable,
  output logic      rc_out
);
  initial rc_out = 1'b0;
  // The period is not a whole number of clocks, so phase drifts freely.
  always #21 rc_out = enable ? ~rc_out : 1'b0;
endmodule // rc_osc_model

// >>> bench/tb_top.sv
// Register-level testbench for the tick watchdog block.
// Assumes fxx equals the 200 MHz clock and the RC model on the pin.
`timescale 1ns/1ps
module tb_top
  import tick_watch_pkg::*;
;
  logic clk, rst, rc_source_select, low_power_enter, stop_release_irq;
  logic reg_write, reg_read, watchdog_reset, cpu_clock_enable;
  logic stabilization_done, rc_osc_enable, base_tick_overflow, rc_osc_pin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int n_mismatch, n_compared, n, i;
  int div [4] = '{4096, 1024, 128, 16};
  tick_watchdog tick_watchdog_i (.clk(clk), .rst(rst), .fxx_en(1'b1),
    .rc_osc_pin(rc_osc_pin), .rc_source_select(rc_source_select),
    .low_power_enter(low_power_enter), .stop_release_irq(stop_release_irq),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .watchdog_reset(watchdog_reset), .cpu_clock_enable(cpu_clock_enable),
    .stabilization_done(stabilization_done), .rc_osc_enable(rc_osc_enable),
    .base_tick_overflow(base_tick_overflow));
  rc_osc_model rc_osc_model_i (.enable(rc_osc_enable), .rc_out(rc_osc_pin));
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  // ****
  // Access tasks
  // ****
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Every task starts and ends at a falling edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    chk(reg_rdata, exp);
  endtask
  task automatic reset_dut();
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
  endtask
  task automatic wait_wdr(input int lim, output int k);
    k = 0;
    while (watchdog_reset !== 1'b1 && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic wait_done();
    for (int k = 0; k < 400 && stabilization_done !== 1'b1; k++)
      @(negedge clk);
    chk({7'h0, cpu_clock_enable}, 8'h01);
  endtask
  task automatic summarize();
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    {rst, reg_write, reg_read, rc_source_select} = 4'h8;
    {low_power_enter, stop_release_irq, reg_addr, reg_wdata} = 18'h0;
    n_mismatch = 0;
    n_compared = 0;
    @(negedge clk);
    reset_dut();
    repeat (4100) @(negedge clk);
    rd(BASE_TICK_COUNTER_ADDR, 8'h01);
    chk({7'h0, cpu_clock_enable}, 8'h00);
    wr(BASE_TICK_CONTROL_ADDR, 8'h0C);
    wait_done();
    rd(BASE_TICK_CONTROL_ADDR, 8'h0C);
    for (i = 1; i < 4; i++) begin
      wr(BASE_TICK_CONTROL_ADDR, {4'h0, i[1:0], 2'b11});
      rd(BASE_TICK_COUNTER_ADDR, 8'h00);
      repeat (div[i] * 5 / 2 - 2) @(negedge clk);
      rd(BASE_TICK_COUNTER_ADDR, 8'h02);
    end
    wr(BASE_TICK_CONTROL_ADDR, 8'h0F);
    wait_wdr(40000, n);
    chk({7'h0, n > 32750 && n < 32790}, 8'h01);
    reset_dut();
    rd(BASE_TICK_CONTROL_ADDR, 8'h00);
    @(negedge clk);
    rd(WATCHDOG_CONTROL_ADDR, 8'h00);
    wr(BASE_TICK_CONTROL_ADDR, 8'h0C);
    wait_done();
    wr(WATCHDOG_CONTROL_ADDR, 8'h5A);
    rd(WATCHDOG_CONTROL_ADDR, 8'h50);
    wr(BASE_TICK_CONTROL_ADDR, 8'hAF);
    wait_wdr(36000, n);
    chk({7'h0, n == 36000}, 8'h01);
    wr(BASE_TICK_CONTROL_ADDR, 8'h0F);
    rc_source_select = 1'b1;
    @(negedge clk);
    wr(WATCHDOG_CONTROL_ADDR, 8'h0A);
    repeat (900) @(negedge clk);
    wr(WATCHDOG_CONTROL_ADDR, 8'h0A);
    wait_wdr(2000, n);
    chk({7'h0, n > 1055 && n < 1100}, 8'h01);
    reset_dut();
    wr(BASE_TICK_CONTROL_ADDR, 8'h0C);
    wait_done();
    wr(WATCHDOG_CONTROL_ADDR, 8'hAA);
    low_power_enter = 1'b1;
    @(negedge clk);
    low_power_enter = 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h0, rc_osc_enable}, 8'h00);
    stop_release_irq = 1'b1;
    @(negedge clk);
    stop_release_irq = 1'b0;
    @(negedge clk);
    chk({7'h0, cpu_clock_enable}, 8'h00);
    wait_done();
    chk({7'h0, rc_osc_enable}, 8'h01);
    summarize();
  end
  initial begin
    #480000;
    n_mismatch++;
    summarize();
  end
endmodule // tb_top

// >>> bench/tick_watchdog_chk.sv
// Port-level checker for the tick watchdog block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module tick_watchdog_chk
  import tick_watch_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       rc_source_select,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       watchdog_reset,
  input wire logic       cpu_clock_enable,
  input wire logic       stabilization_done,
  input wire logic       rc_osc_enable,
  input wire logic       base_tick_overflow
);
  // ****
  // Assertions
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_OVF_PULSE:
  assert property (base_tick_overflow |=> !base_tick_overflow)
    else $error("overflow strobe too long");
  AST_WDR_PULSE:
  assert property (watchdog_reset |=> !watchdog_reset)
    else $error("watchdog reset too long");
  AST_RST_STATE:
  assert property (disable iff (1'b0) rst |=> reg_rdata == 8'h00 &&
    !watchdog_reset && !cpu_clock_enable && !stabilization_done &&
    rc_osc_enable && !base_tick_overflow)
    else $error("wrong state after reset");
  AST_GATE:
  assert property (!stabilization_done |-> !cpu_clock_enable)
    else $error("cpu clock ran before stabilization");
  AST_RISE:
  assert property ($rose(cpu_clock_enable) |-> $rose(stabilization_done))
    else $error("cpu clock and done out of step");
  AST_RC_STOP:
  assert property (!rc_osc_enable |-> rc_source_select)
    else $error("oscillator stopped while not selected");
  AST_TICK_SRC:
  assert property ($rose(watchdog_reset) && !rc_source_select |->
    $past(base_tick_overflow, 1) || $past(base_tick_overflow, 2) ||
    $past(base_tick_overflow, 3))
    else $error("watchdog reset without base overflow");
  AST_CNT_CLR:
  assert property (reg_write && reg_addr == BASE_TICK_CONTROL_ADDR &&
    reg_wdata[1] ##1 reg_read && reg_addr == BASE_TICK_COUNTER_ADDR
    |=> reg_rdata == 8'h00)
    else $error("base counter not cleared");
  AST_NIB_CLR:
  assert property (reg_write && reg_addr == WATCHDOG_CONTROL_ADDR &&
    reg_wdata[3:0] == SIGNATURE_CODE ##1 reg_read &&
    reg_addr == WATCHDOG_CONTROL_ADDR |=> reg_rdata[3:0] == 4'h0)
    else $error("clear nibble not returned to zero");
  cover property (watchdog_reset);
  cover property ($rose(stabilization_done));
  cover property (!rc_osc_enable);
endmodule // tick_watchdog_chk
bind tick_watchdog tick_watchdog_chk tick_watchdog_chk_i (
  .clk(clk), .rst(rst), .rc_source_select(rc_source_select),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata),
  .watchdog_reset(watchdog_reset), .cpu_clock_enable(cpu_clock_enable),
  .stabilization_done(stabilization_done), .rc_osc_enable(rc_osc_enable),
  .base_tick_overflow(base_tick_overflow));

// >>> hdl/rate_divider.sv
// Prescaler producing one-cycle enable pulses at fxx/4096, /1024, /128, /16.
// Assumes fxx_en marks each fxx period on the one system clock.
`timescale 1ns/1ps
module rate_divider
  import tick_watch_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       fxx_en,
  input  wire logic                       divider_clear,
  input  wire rate_select_type            rate_select,
  output logic                            tick_en
);

  logic [DIVIDER_WIDTH-1:0] div_reg;
  logic                     hit;

  always_ff @(posedge clk) begin
    if (rst || divider_clear) begin
      div_reg <= '0;
    end else if (fxx_en) begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // A tap fires when every bit below it is set on the counting edge.
  always_comb begin
    case (rate_select)
      RATE_DIV4096: hit = &div_reg[11:0];
      RATE_DIV1024: hit = &div_reg[9:0];
      RATE_DIV128:  hit = &div_reg[6:0];
      RATE_DIV16:   hit = &div_reg[3:0];
      default:      hit = &div_reg[11:0];
    endcase
  end

  assign tick_en = fxx_en && hit && !divider_clear;

endmodule // rate_divider

// >>> hdl/tick_watch_pkg.sv
// Constants shared by the base tick timer and watchdog design.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
package tick_watch_pkg;

  localparam logic [7:0] WATCHDOG_CONTROL_ADDR  = 8'hF2;
  localparam logic [7:0] BASE_TICK_CONTROL_ADDR = 8'hD3;
  localparam logic [7:0] BASE_TICK_COUNTER_ADDR = 8'hFD;
  localparam logic [7:0] CONTROL_RESET          = 8'h00;
  localparam logic [3:0] SIGNATURE_CODE         = 4'hA;
  localparam int         CLEAR_BIT_POS          = 1;
  localparam int         DIVIDER_CLEAR_BIT_POS  = 0;
  localparam int         STAB_BIT_POS           = 3;
  localparam int         TICK_OVF_BIT_POS       = 3;
  localparam int         RC_OVF_BIT_POS         = 7;
  localparam int         DIVIDER_WIDTH          = 12;

  typedef enum logic [1:0] {
    RATE_DIV4096,
    RATE_DIV1024,
    RATE_DIV128,
    RATE_DIV16
  } rate_select_type;

endpackage

// >>> hdl/tick_watchdog.sv
// Base tick timer, watchdog counter and oscillation stabilisation timer.
// Assumes an 8-bit register port from the CPU core with one-cycle strobes,
// an fxx enable pulse from clock control and an RC ring oscillator pin.
`timescale 1ns/1ps
module tick_watchdog
  import tick_watch_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        fxx_en,
  input  wire logic        rc_osc_pin,
  input  wire logic        rc_source_select,
  input  wire logic        low_power_enter,
  input  wire logic        stop_release_irq,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  output logic             watchdog_reset,
  output logic             cpu_clock_enable,
  output logic             stabilization_done,
  output logic             rc_osc_enable,
  output logic             base_tick_overflow
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [7:0]       base_tick_control_reg;
  logic [3:0]       rc_stop_code_reg;
  logic [3:0]       clear_nibble_reg;
  logic [7:0]       base_tick_counter_reg;
  logic [7:0]       watchdog_count_reg;
  logic             stabilizing_reg;
  logic             low_power_reg;
  logic [2:0]       rc_sync_reg;
  logic             rc_level_reg;
  logic             tick_en;
  logic             rc_edge;
  logic             wr_control;
  logic             wr_watchdog;
  logic             counter_clear;
  logic             watchdog_clear;
  logic             watchdog_step;
  logic             watchdog_enabled;
  logic             overflow_hit;
  logic             rc_stopped;
  rate_select_type  rate_select;

  assign wr_control  = reg_write && (reg_addr == BASE_TICK_CONTROL_ADDR);
  assign wr_watchdog = reg_write && (reg_addr == WATCHDOG_CONTROL_ADDR);
  assign counter_clear = wr_control && reg_wdata[CLEAR_BIT_POS];
  assign watchdog_clear = counter_clear
    || (wr_watchdog && reg_wdata[3:0] == SIGNATURE_CODE);
  assign rate_select = rate_select_type'(base_tick_control_reg[3:2]);
  assign watchdog_enabled =
    base_tick_control_reg[7:4] != SIGNATURE_CODE;
  assign rc_stopped = rc_source_select && low_power_reg
    && (rc_stop_code_reg == SIGNATURE_CODE);

  // ************************************************************
  // Registers written by software
  // ************************************************************
  // Clear bits are strobes: they act on the write and are never stored.
  always_ff @(posedge clk) begin
    if (rst) begin
      base_tick_control_reg <= CONTROL_RESET;
    end else if (wr_control) begin
      base_tick_control_reg <= {reg_wdata[7:2], 2'b00};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rc_stop_code_reg <= CONTROL_RESET[7:4];
      clear_nibble_reg <= CONTROL_RESET[3:0];
    end else begin
      if (wr_watchdog) begin
        rc_stop_code_reg <= reg_wdata[7:4];
      end
      // The nibble reads back zero once the clear has taken effect.
      clear_nibble_reg <= CONTROL_RESET[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        BASE_TICK_CONTROL_ADDR: reg_rdata <= base_tick_control_reg;
        WATCHDOG_CONTROL_ADDR:
          reg_rdata <= {rc_stop_code_reg, clear_nibble_reg};
        BASE_TICK_COUNTER_ADDR: reg_rdata <= base_tick_counter_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ************************************************************
  // Base tick counter
  // ************************************************************
  rate_divider u_rate_divider (
    .clk           (clk),
    .rst           (rst),
    .fxx_en        (fxx_en),
    .divider_clear (wr_control && reg_wdata[DIVIDER_CLEAR_BIT_POS]),
    .rate_select   (rate_select),
    .tick_en       (tick_en)
  );

  always_ff @(posedge clk) begin
    if (rst || counter_clear) begin
      base_tick_counter_reg <= 8'h00;
    end else if (tick_en) begin
      base_tick_counter_reg <= base_tick_counter_reg + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      base_tick_overflow <= 1'b0;
    end else begin
      base_tick_overflow <= tick_en && !counter_clear
        && (base_tick_counter_reg == 8'hFF);
    end
  end

  // ************************************************************
  // RC oscillator sampling and power state
  // ************************************************************
  // Only the first stage sees the raw pin. A new level is accepted once
  // stages two and three agree, so a glitch that lives a single clock is
  // dropped at the cost of one more cycle of latency.
  always_ff @(posedge clk) begin
    if (rst) begin
      rc_sync_reg <= 3'b000;
    end else begin
      rc_sync_reg <= {rc_sync_reg[1:0], rc_osc_pin};
    end
  end

  // The filtered level resets to the idle low level of the pin, so no
  // false edge follows reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      rc_level_reg <= 1'b0;
    end else if (rc_sync_reg[1] == rc_sync_reg[2]) begin
      rc_level_reg <= rc_sync_reg[2];
    end
  end

  assign rc_edge = rc_sync_reg[1] && rc_sync_reg[2] && !rc_level_reg;

  always_ff @(posedge clk) begin
    if (rst || stop_release_irq) begin
      low_power_reg <= 1'b0;
    end else if (low_power_enter) begin
      low_power_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rc_osc_enable <= 1'b1;
    end else begin
      rc_osc_enable <= !rc_stopped;
    end
  end

  // ************************************************************
  // Watchdog counter
  // ************************************************************
  // The bit-3 tap trips on the eighth wrap of the base counter, giving a
  // short window; RC mode uses bit 7 because that source runs much faster.
  assign watchdog_step = rc_source_select ? rc_edge : base_tick_overflow;
  assign overflow_hit = watchdog_step && (rc_source_select
    ? watchdog_count_reg[RC_OVF_BIT_POS - 1:0] == 7'h7F
    : watchdog_count_reg[TICK_OVF_BIT_POS - 1:0] == 3'h7);

  always_ff @(posedge clk) begin
    if (rst || watchdog_clear) begin
      watchdog_count_reg <= 8'h00;
    end else if (rc_source_select && low_power_enter
                 && rc_stop_code_reg == SIGNATURE_CODE) begin
      watchdog_count_reg <= 8'h00;
    end else if (overflow_hit) begin
      watchdog_count_reg <= 8'h00;
    end else if (watchdog_step && !rc_stopped) begin
      watchdog_count_reg <= watchdog_count_reg + 8'h01;
    end
  end

  // The pulse feeds the chip reset, which in turn clears this block.
  always_ff @(posedge clk) begin
    if (rst) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= overflow_hit && !watchdog_clear
        && watchdog_enabled;
    end
  end

  // ************************************************************
  // Oscillation stabilisation
  // ************************************************************
  // After reset, or a release from stop, the CPU waits for bit 3 of the
  // base counter to carry out.
  always_ff @(posedge clk) begin
    if (rst || stop_release_irq) begin
      stabilizing_reg <= 1'b1;
    end else if (tick_en && !counter_clear
                 && base_tick_counter_reg[STAB_BIT_POS:0] == 4'hF) begin
      stabilizing_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_clock_enable   <= 1'b0;
      stabilization_done <= 1'b0;
    end else begin
      cpu_clock_enable   <= !stabilizing_reg && !low_power_reg;
      stabilization_done <= !stabilizing_reg;
    end
  end

endmodule // tick_watchdog
